// ==== rtc_pkg.sv ====
/*
 * Shared constants for the real-time counter control block: register
 * addresses, bit positions, reset values, sub-second counter limits and
 * the periodic tick and hold handshake encodings.
 * Assumes an 8-bit CPU data path with 16-bit byte addresses.
 */
package rtc_pkg;

    localparam logic [15:0] RTC_ADDR_MAIN_CTL = 16'hFF7D;
    localparam logic [15:0] RTC_ADDR_ALARM_WAIT = 16'hFF7E;

    localparam logic [7:0] RTC_MAIN_CTL_RST = 8'h00;
    localparam logic [7:0] RTC_ALARM_WAIT_RST = 8'h00;
    // Bit 6 of the main control register is fixed at zero
    localparam logic [7:0] RTC_MAIN_CTL_MASK = 8'hBF;
    localparam logic [7:0] RTC_BYTE_ZERO = 8'h00;

    // Main control register fields
    localparam int RTC_MC_RUN = 7;
    localparam int RTC_MC_SEC_OUT = 5;
    localparam int RTC_MC_BASE_OUT = 4;
    localparam int RTC_MC_HOUR_FMT = 3;
    localparam int RTC_MC_SEL_HI = 2;

    // Alarm and wait control register fields
    localparam int RTC_AW_MATCH_EN = 7;
    localparam int RTC_AW_IRQ_EN = 6;
    localparam int RTC_AW_ALARM_FLAG = 4;
    localparam int RTC_AW_PER_FLAG = 3;
    localparam int RTC_AW_HOLD_STS = 1;
    localparam int RTC_AW_HOLD_REQ = 0;

    // Sub-second counter: one second of the 32.768 kHz clock
    localparam logic [14:0] RTC_SUB_ZERO = 15'h0000;
    localparam logic [14:0] RTC_SUB_MAX = 15'h7FFF;
    localparam logic [14:0] RTC_SUB_HALF = 15'h3FFF;
    localparam logic [14:0] RTC_SUB_ONE = 15'h0001;

    typedef enum logic [2:0] {
        RTC_PER_NONE = 3'h0,
        RTC_PER_HALF_SEC = 3'h1,
        RTC_PER_SECOND = 3'h2,
        RTC_PER_MINUTE = 3'h3,
        RTC_PER_HOUR = 3'h4,
        RTC_PER_DAY = 3'h5,
        RTC_PER_MONTH = 3'h6,
        RTC_PER_MONTH_ALT = 3'h7
    } rtc_per_sel_e;

    // Gray order along running, waiting, held
    typedef enum logic [1:0] {
        RTC_HOLD_RUN = 2'h0,
        RTC_HOLD_WAIT = 2'h1,
        RTC_HOLD_HELD = 2'h3
    } rtc_hold_state_e;

endpackage : rtc_pkg

// ==== rtc_subsec.sv ====
/*
 * Sub-second counter of the real-time counter. Advances once per
 * 32.768 kHz tick while running and marks the half and full second.
 * Assumes sub_tick is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/1ns
module rtc_subsec (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sub_tick,
    input wire logic run,
    input wire logic clear,
    output logic [14:0] count,
    output logic half_pulse,
    output logic ovf_pulse
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [14:0] cnt;
        logic half;
        logic ovf;
    } rtc_sub_s;

    rtc_sub_s st_reg;
    rtc_sub_s st_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.half = 1'b0;
        st_next.ovf = 1'b0;
        if (clear) begin
            st_next.cnt = RTC_SUB_ZERO;
        end else if (run && sub_tick) begin
            if (st_reg.cnt == RTC_SUB_MAX) begin
                st_next.cnt = RTC_SUB_ZERO;
                st_next.ovf = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + RTC_SUB_ONE;
            end
            if (st_reg.cnt == RTC_SUB_HALF) begin
                st_next.half = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.cnt;
    assign half_pulse = st_reg.half;
    assign ovf_pulse = st_reg.ovf;

endmodule : rtc_subsec

// ==== rtc_ctrl.sv ====
/*
 * Control section of the real-time counter: the two control registers,
 * run and stop, pin outputs, hour format, periodic tick and alarm flags
 * on one shared interrupt, and the count hold handshake.
 * Assumes the calendar counters sit outside, take sec_advance and
 * counters_frozen, and report the wraps that the next advance causes.
 * All inputs are synchronous to core_clk; sub_clk is the sampled
 * 32.768 kHz subsystem clock.
 */
`timescale 1ns/1ns
module rtc_ctrl (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic sub_clk,
    input wire logic seconds_write,
    input wire logic alarm_match,
    input wire logic wrap_minute,
    input wire logic wrap_hour,
    input wire logic wrap_day,
    input wire logic wrap_month,
    output logic sec_advance,
    output logic counters_frozen,
    output logic hour_format_select,
    output logic second_pulse_pin,
    output logic base_clock_pin,
    output logic rtc_shared_irq
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [7:0] main_ctl;
        logic alarm_match_enable;
        logic alarm_irq_enable;
        logic alarm_hit_flag;
        logic periodic_hit_flag;
        logic count_hold_request;
        rtc_hold_state_e hold;
        logic pend_adv;
        logic sub_q;
        logic match_q;
        logic match_seen;
        logic [7:0] rdata;
        logic adv;
        logic irq;
        logic sec_pin;
        logic base_pin;
    } rtc_ctrl_s;

    rtc_ctrl_s st_reg;
    rtc_ctrl_s st_next;

    logic sub_tick;
    logic [14:0] sub_count;
    logic sub_half;
    logic sub_ovf;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the periodic tick selection

    function automatic logic rtc_per_due(
        input logic [2:0] sel,
        input logic adv,
        input logic half,
        input logic w_min,
        input logic w_hour,
        input logic w_day,
        input logic w_month
    );
        logic due;
        due = 1'b0;
        case (rtc_per_sel_e'(sel))
            RTC_PER_NONE: due = 1'b0;
            RTC_PER_HALF_SEC: due = adv | half;
            RTC_PER_SECOND: due = adv;
            RTC_PER_MINUTE: due = adv & w_min;
            RTC_PER_HOUR: due = adv & w_hour;
            RTC_PER_DAY: due = adv & w_day;
            RTC_PER_MONTH: due = adv & w_month;
            RTC_PER_MONTH_ALT: due = adv & w_month;
            default: due = 1'b0;
        endcase
        return due;
    endfunction : rtc_per_due

    function automatic logic rtc_hit(
        input logic [15:0] addr,
        input logic [15:0] target,
        input logic strobe
    );
        return strobe && (addr == target);
    endfunction : rtc_hit

    ////////////////////////////////////////////////////////////////////////
    // Inputs are synchronous, so the edge is taken from one stored sample
    assign sub_tick = sub_clk & ~st_reg.sub_q;

    // Run bit gates the sub-second count
    // Stopping here stops new events from the count, but an overflow already pending under hold still advances on release
    rtc_subsec i_rtc_subsec (
        .core_clk(core_clk),
        .rstn(rstn),
        .sub_tick(sub_tick),
        .run(st_reg.main_ctl[RTC_MC_RUN]),
        .clear(seconds_write),
        .count(sub_count),
        .half_pulse(sub_half),
        .ovf_pulse(sub_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic wr_main;
        logic wr_aw;
        logic per_ev;
        logic alarm_ev;
        logic do_adv;
        wr_main = rtc_hit(cpu_addr, RTC_ADDR_MAIN_CTL, cpu_wr);
        wr_aw = rtc_hit(cpu_addr, RTC_ADDR_ALARM_WAIT, cpu_wr);
        per_ev = 1'b0;
        alarm_ev = 1'b0;
        do_adv = 1'b0;
        st_next = st_reg;
        st_next.sub_q = sub_clk;
        st_next.adv = 1'b0;
        st_next.irq = 1'b0;

        if (wr_main) begin
            st_next.main_ctl = cpu_wdata & RTC_MAIN_CTL_MASK;
        end
        if (wr_aw) begin
            st_next.alarm_match_enable = cpu_wdata[RTC_AW_MATCH_EN];
            st_next.alarm_irq_enable = cpu_wdata[RTC_AW_IRQ_EN];
            st_next.count_hold_request = cpu_wdata[RTC_AW_HOLD_REQ];
            if (!cpu_wdata[RTC_AW_ALARM_FLAG]) begin
                st_next.alarm_hit_flag = 1'b0;
            end
            if (!cpu_wdata[RTC_AW_PER_FLAG]) begin
                st_next.periodic_hit_flag = 1'b0;
            end
        end

        // Hold handshake timing
        // Release is immediate; a request dropped while waiting aborts it
        // Held is only entered on a sub tick, but counters_frozen already rises
        // on entry to waiting, so counters may stop in the middle of a calendar update
        case (st_reg.hold)
            RTC_HOLD_RUN: begin
                if (st_reg.count_hold_request) begin
                    st_next.hold = RTC_HOLD_WAIT;
                end
            end
            RTC_HOLD_WAIT: begin
                if (!st_reg.count_hold_request) begin
                    st_next.hold = RTC_HOLD_RUN;
                end else if (sub_tick) begin
                    st_next.hold = RTC_HOLD_HELD;
                end
            end
            RTC_HOLD_HELD: begin
                if (!st_reg.count_hold_request) begin
                    st_next.hold = RTC_HOLD_RUN;
                    do_adv = st_reg.pend_adv;
                    st_next.pend_adv = 1'b0;
                end
            end
            default: st_next.hold = RTC_HOLD_RUN;
        endcase

        // Freeze seconds upward
        // A held overflow is given out on release from held; one in the release cycle or an aborted wait stays pending until a later release
        if (sub_ovf) begin
            if (st_reg.hold == RTC_HOLD_RUN) begin
                do_adv = 1'b1;
            end else begin
                st_next.pend_adv = 1'b1;
            end
        end
        if (seconds_write) begin
            st_next.pend_adv = 1'b0;
            if (st_reg.hold != RTC_HOLD_RUN) begin
                do_adv = 1'b0;
            end
        end
        st_next.adv = do_adv;

        // Match seen, flag next subclock
        // Only a fresh rise of the match counts, so a long match fires once
        alarm_ev = 1'b0;
        if (sub_tick) begin
            st_next.match_q = alarm_match;
            st_next.match_seen = 1'b0;
            if (st_reg.match_seen && st_reg.alarm_match_enable) begin
                alarm_ev = 1'b1;
            end
            if (alarm_match && !st_reg.match_q) begin
                st_next.match_seen = 1'b1;
            end
        end
        if (!st_reg.alarm_match_enable) begin
            st_next.match_seen = 1'b0;
        end

        per_ev = rtc_per_due(st_reg.main_ctl[RTC_MC_SEL_HI:0], do_adv,
            sub_half, wrap_minute, wrap_hour, wrap_day, wrap_month);

        if (per_ev) begin
            st_next.periodic_hit_flag = 1'b1;
        end
        if (alarm_ev) begin
            st_next.alarm_hit_flag = 1'b1;
        end
        st_next.irq = per_ev | (alarm_ev & st_reg.alarm_irq_enable);

        // Enables act at once, so a short pulse may appear
        st_next.base_pin = st_reg.main_ctl[RTC_MC_BASE_OUT] & sub_clk;
        // High for the first half of each second
        st_next.sec_pin = st_reg.main_ctl[RTC_MC_SEC_OUT] &
            (sub_count <= RTC_SUB_HALF);

        // Read data stands one cycle, so an idle bus reads zero
        st_next.rdata = RTC_BYTE_ZERO;
        if (rtc_hit(cpu_addr, RTC_ADDR_MAIN_CTL, cpu_rd)) begin
            st_next.rdata = st_reg.main_ctl;
        end else if (rtc_hit(cpu_addr, RTC_ADDR_ALARM_WAIT, cpu_rd)) begin
            st_next.rdata[RTC_AW_MATCH_EN] = st_reg.alarm_match_enable;
            st_next.rdata[RTC_AW_IRQ_EN] = st_reg.alarm_irq_enable;
            st_next.rdata[RTC_AW_ALARM_FLAG] = st_reg.alarm_hit_flag;
            st_next.rdata[RTC_AW_PER_FLAG] = st_reg.periodic_hit_flag;
            st_next.rdata[RTC_AW_HOLD_STS] =
                (st_reg.hold == RTC_HOLD_HELD);
            st_next.rdata[RTC_AW_HOLD_REQ] = st_reg.count_hold_request;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
            st_reg.main_ctl <= RTC_MAIN_CTL_RST;
            st_reg.hold <= RTC_HOLD_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign cpu_rdata = st_reg.rdata;
    assign sec_advance = st_reg.adv;
    // Only the running state has bit 0 clear in the Gray order
    assign counters_frozen = st_reg.hold[0];
    assign hour_format_select = st_reg.main_ctl[RTC_MC_HOUR_FMT];
    assign second_pulse_pin = st_reg.sec_pin;
    assign base_clock_pin = st_reg.base_pin;
    assign rtc_shared_irq = st_reg.irq;

endmodule : rtc_ctrl

// ==== rtc_ctrl_properties.sv ====
/* Port checker for rtc_ctrl.
   Assumes a bind to rtc_ctrl; control bytes are shadowed from writes. */
`timescale 1ns/1ns
module rtc_ctrl_properties (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic sub_clk,
    input wire logic sec_advance,
    input wire logic counters_frozen,
    input wire logic hour_format_select,
    input wire logic second_pulse_pin,
    input wire logic base_clock_pin,
    input wire logic rtc_shared_irq
);
    import rtc_pkg::*;
    logic [7:0] mc_reg;
    logic [7:0] aw_reg;
    logic hold_wr;
    assign hold_wr = cpu_wr && cpu_addr == RTC_ADDR_ALARM_WAIT;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mc_reg <= RTC_BYTE_ZERO;
            aw_reg <= RTC_BYTE_ZERO;
        end else if (cpu_wr) begin
            if (cpu_addr == RTC_ADDR_MAIN_CTL) mc_reg <= cpu_wdata;
            if (hold_wr) aw_reg <= cpu_wdata;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    reg_readback_a: assert property (
        $past(cpu_rd && cpu_addr == RTC_ADDR_MAIN_CTL)
        |-> cpu_rdata == ($past(mc_reg) & RTC_MAIN_CTL_MASK))
        else $error("main control read back wrong");
    read_idle_a: assert property (!$past(cpu_rd) |-> cpu_rdata == 8'h00)
        else $error("read data not idle");
    hour_format_a: assert property (
        hour_format_select == mc_reg[RTC_MC_HOUR_FMT])
        else $error("hour format not from register");
    base_pin_off_a: assert property (
        !mc_reg[4] && !$past(mc_reg[4]) |-> !base_clock_pin)
        else $error("base clock pin driven while off");
    base_pin_copy_a: assert property (
        mc_reg[4] && $past(mc_reg[4]) |-> base_clock_pin == $past(sub_clk))
        else $error("base clock pin not following clock");
    second_pin_off_a: assert property (
        !mc_reg[5] && !$past(mc_reg[5]) |-> !second_pulse_pin)
        else $error("second pulse pin driven while off");
    irq_pulse_a: assert property (rtc_shared_irq |=> !rtc_shared_irq)
        else $error("interrupt longer than one cycle");
    irq_quiet_a: assert property (
        mc_reg[2:0] == 3'h0 && !aw_reg[6] && $past(mc_reg[2:0]) == 3'h0
        && !$past(aw_reg[6]) |-> !rtc_shared_irq)
        else $error("interrupt with all sources off");
    advance_stop_a: assert property (
        !mc_reg[7] && !$past(mc_reg[7]) && !$past(mc_reg[7], 2)
        && !$past(counters_frozen) |-> !sec_advance)
        else $error("seconds advance while stopped");
    hold_freeze_a: assert property (
        hold_wr && cpu_wdata[0] |-> ##[1:3] counters_frozen)
        else $error("hold request did not freeze");
    hold_release_a: assert property (
        hold_wr && !cpu_wdata[0] |-> ##[1:3] !counters_frozen)
        else $error("hold release did not resume");
    cover property (rtc_shared_irq && mc_reg[2:0] != 3'h0);
    cover property (rtc_shared_irq && aw_reg[6]);
    cover property (sec_advance);
endmodule : rtc_ctrl_properties

bind rtc_ctrl rtc_ctrl_properties i_rtc_ctrl_properties (
    .core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .sub_clk(sub_clk), .sec_advance(sec_advance),
    .counters_frozen(counters_frozen),
    .hour_format_select(hour_format_select),
    .second_pulse_pin(second_pulse_pin),
    .base_clock_pin(base_clock_pin), .rtc_shared_irq(rtc_shared_irq));

// ==== rtc_control_and_wait_logic_tb.sv ====
/* Self-checking bench for rtc_ctrl.
   Assumes sub_clk may be sped up: one sub tick every two core cycles. */
`timescale 1ns/1ns
module rtc_control_and_wait_logic_tb;
    import rtc_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic [7:0] cpu_wdata = 8'h00;
    logic sub_clk = 1'b0;
    logic seconds_write = 1'b0;
    logic alarm_match = 1'b0;
    logic [3:0] wraps = 4'h0;
    logic [7:0] cpu_rdata;
    logic sec_advance, counters_frozen, hour_format_select;
    logic second_pulse_pin, base_clock_pin, rtc_shared_irq;
    logic [7:0] v;
    int errors = 0;
    int comparisons = 0;
    int irq_cnt = 0;
    int adv_cnt = 0;
    int cycles = 0;
    int c, sub, n0, a0;
    int exp_irq = 0;
    always #25 core_clk = ~core_clk;
    rtc_ctrl i_rtc_ctrl (
        .core_clk(core_clk), .rstn(rstn), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .sub_clk(sub_clk),
        .seconds_write(seconds_write), .alarm_match(alarm_match),
        .wrap_minute(wraps[0]), .wrap_hour(wraps[1]),
        .wrap_day(wraps[2]), .wrap_month(wraps[3]),
        .sec_advance(sec_advance), .counters_frozen(counters_frozen),
        .hour_format_select(hour_format_select),
        .second_pulse_pin(second_pulse_pin),
        .base_clock_pin(base_clock_pin), .rtc_shared_irq(rtc_shared_irq));
    ////////////////////////////////////////
    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        cpu_wr <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge core_clk);
        cpu_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        cpu_rd <= 1'b1;
        cpu_addr <= a;
        @(posedge core_clk);
        cpu_rd <= 1'b0;
        #1;
        check(cpu_rdata, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            sub_clk <= 1'b1;
            @(posedge core_clk);
            sub_clk <= 1'b0;
        end
    endtask : tick
    // Event counts and hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (rtc_shared_irq === 1'b1) irq_cnt++;
        if (sec_advance === 1'b1) adv_cnt++;
        if (cycles == 90000) begin
            errors++;
            results();
        end
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h7B6431B8));
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        rd(RTC_ADDR_MAIN_CTL, RTC_MAIN_CTL_RST);
        rd(RTC_ADDR_ALARM_WAIT, RTC_ALARM_WAIT_RST);
        rd(16'hFF7F, RTC_BYTE_ZERO);
        // counts held while the hour format changes
        wr(RTC_ADDR_ALARM_WAIT, 8'h01);
        // the divided output lives outside, base enable is free
        repeat (8) begin
            v = 8'($urandom);
            wr(RTC_ADDR_MAIN_CTL, v);
            rd(RTC_ADDR_MAIN_CTL, v & RTC_MAIN_CTL_MASK);
            check({7'h00, hour_format_select}, {7'h00, v[3]});
        end
        // Hold status waits for a sub tick
        wr(RTC_ADDR_ALARM_WAIT, 8'h01);
        rd(RTC_ADDR_ALARM_WAIT, 8'h01);
        check({7'h00, counters_frozen}, 8'h01);
        tick(1);
        rd(RTC_ADDR_ALARM_WAIT, 8'h03);
        wr(RTC_ADDR_ALARM_WAIT, 8'h00);
        rd(RTC_ADDR_ALARM_WAIT, 8'h00);
        check({7'h00, counters_frozen}, 8'h00);
        // Every pairing of the two alarm enables
        wr(RTC_ADDR_MAIN_CTL, 8'h80);
        for (c = 0; c < 4; c++) begin
            v = 8'(c << 6);
            // alarm interrupt enable written before match enable
            wr(RTC_ADDR_ALARM_WAIT, v & 8'h7F);
            wr(RTC_ADDR_ALARM_WAIT, v);
            n0 = irq_cnt;
            alarm_match <= 1'b1;
            tick(3);
            alarm_match <= 1'b0;
            tick(1);
            rd(RTC_ADDR_ALARM_WAIT, v | (v[7] ? 8'h10 : 8'h00));
            check(8'(irq_cnt - n0), {7'h00, v[7] & v[6]});
            // match enable off and flags cleared together
            wr(RTC_ADDR_ALARM_WAIT, 8'h00);
        end
        // One full second from a cleared sub-second count
        @(posedge core_clk);
        seconds_write <= 1'b1;
        @(posedge core_clk);
        seconds_write <= 1'b0;
        wr(RTC_ADDR_MAIN_CTL, 8'hB1);
        n0 = irq_cnt;
        a0 = adv_cnt;
        c = 2 + $urandom_range(5);
        for (sub = 1; sub <= 32768; sub++) begin
            tick(1);
            if (sub == 16384) exp_irq++;
            if (sub == 8192 || sub == 24576) begin
                #1;
                check({7'h00, second_pulse_pin}, {7'h00, sub == 8192});
            end
            if (sub == 16400) begin
                // select changed, flags cleared at the end
                wr(RTC_ADDR_MAIN_CTL, 8'hB0 | 8'(c));
                wraps <= 4'($urandom);
            end
            // short hold over the overflow, flags kept as ones
            if (sub == 32760) wr(RTC_ADDR_ALARM_WAIT, 8'h19);
        end
        repeat (4) @(posedge core_clk);
        check(8'(adv_cnt - a0), 8'h00);
        exp_irq += (c == 2) ? 1 : int'(wraps[(c > 6 ? 6 : c) - 3]);
        wr(RTC_ADDR_ALARM_WAIT, 8'h18);
        repeat (4) @(posedge core_clk);
        check(8'(irq_cnt - n0), 8'(exp_irq));
        check(8'(adv_cnt - a0), 8'h01);
        rd(RTC_ADDR_ALARM_WAIT, 8'h08);
        wr(RTC_ADDR_ALARM_WAIT, 8'h18);
        rd(RTC_ADDR_ALARM_WAIT, 8'h08);
        // flags cleared after the select change
        wr(RTC_ADDR_ALARM_WAIT, 8'h00);
        rd(RTC_ADDR_ALARM_WAIT, 8'h00);
        results();
    end
endmodule : rtc_control_and_wait_logic_tb
